// File: src/fdoc_map.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * floppy drive output control block.
 * assumes a byte-wide register set on an avalon-mm byte-addressed bus.
 */
`ifndef FDOC_MAP_SVH
`define FDOC_MAP_SVH

// printed register indices (byte address is four times the index)
`define FDOC_IDX_STATUS_B 10'h3F1
`define FDOC_IDX_DRV_CTRL 10'h3F2
`define FDOC_IDX_TAPE_SEL 10'h3F3
`define FDOC_IDX_DIG_IN 10'h3F7
`define FDOC_ADDR_W 12

// drive output control field positions
`define FDOC_DOC_SEL_LO 0
`define FDOC_DOC_RST_N 2
`define FDOC_DOC_DMA_EN 3
`define FDOC_DOC_MTR_LO 4

// reset values
`define FDOC_DOC_RESET 8'h00
`define FDOC_TSS_RESET 2'h0

// least software reset pulse
`define FDOC_SRST_MIN_NS 100
`define FDOC_CLK_NS 8
`define FDOC_SRST_CYC ((`FDOC_SRST_MIN_NS + `FDOC_CLK_NS - 1) / `FDOC_CLK_NS)

`endif

// File: src/fdoc_pkg.sv
/*
 * types of the floppy drive output control block.
 * assumes fdoc_map.svh for numeric constants.
 */
package fdoc_pkg;

  // register set layout chosen by strapping
  typedef enum logic [1:0] {
    fdoc_mode_basic,
    fdoc_mode_extended,
    fdoc_mode_alternate
  } fdoc_mode_t;

  // bus answer sequencing
  typedef enum logic [0:0] {
    fdoc_bus_idle,
    fdoc_bus_ack
  } fdoc_bus_t;

  typedef struct packed {
    fdoc_bus_t bus;
    logic [7:0] doc;
    logic [1:0] tss;
    logic [7:0] rdata;
    logic [7:0] rd_tri;
    logic wg_sync1;
    logic wg_sync2;
    logic wg_last;
    logic rd_sync1;
    logic rd_sync2;
    logic rd_last;
    logic wd_sync1;
    logic wd_sync2;
    logic wd_last;
    logic wg_latch;
    logic rd_latch;
    logic wd_latch;
    logic rd_tog;
    logic wd_tog;
    logic [3:0] rst_cnt;
    logic ctl_rst;
  } fdoc_state_t;

endpackage

// File: src/fdoc_top.sv
/*
 * floppy drive output control: drive output control register, tape select
 * store, disk status b and the drive select / motor decode.
 * the block answers every register access after one wait cycle, keeps the
 * drive output control and tape select through a soft reset, and stretches
 * the controller reset so that two back-to-back writes still give a pulse
 * long enough for the core.
 * the status b layout, the decode style and the drive swap come from strap
 * inputs; the read data and ctl_reset are registered, the drive pins are decoded
 * combinationally from the stored register.
 * assumes an avalon-mm master on clk, synchronous drive-side inputs and a
 * core outside that uses ctl_reset and the dma pin enables.
 * assumes the strap inputs stay still while the bus is busy; a strap that
 * moves mid-read may mix two layouts in one status value.
 * assumes the pads outside turn avs_readdata_tri into per-bit bus floats.
 */
// Our own choice: the Avalon-MM register port.
// Summary of operation
// - extended mode: status b bit 7 always reads one.
// - alternate mode: status b shows active-low selects 2,3,0,1 in bits 0,1,5,6.
// - alternate mode: status b bit 7 follows second-drive-present pin.
// - alternate mode: bit 2 latches write gate rise, cleared by input read.
// - alternate mode: bit 3 latches read data fall, cleared by input read.
// - alternate mode: bit 4 latches write data fall, ungated, cleared likewise.
// - drive output control clears on hardware reset, kept through soft reset.
// - drive output control is writable at any time and reads back.
// - bits 1:0 encode which one of four drives is selected.
// - bit 2 low holds controller reset; other registers untouched.
// - soft reset lasts at least 100 ns; back-to-back toggling works.
// - basic/alternate: bit 3 enables dma and interrupt pins, else floated.
// - extended mode: dma and interrupt pins always enabled, even in reset.
// - bits 7:4 drive motor outputs 3:0, one means active.
// - tape select stores two bits, unused inside, kept through soft reset.
// - tape select read in normal mode floats data bits 7:2.
// - internal decode: coded select low only with its motor bit set.
// - internal swapped decode: drives 0 and 1 exchange selects and motors.
// - external decode: selects carry code bits, motor 0 low if selected on.
// - external swapped decode: codes 00 and 01 exchanged on selects.
// - status b readable in extended mode, floats in basic mode.
// - extended mode: status b bit 5 mirrors select code bit 0.
// - extended mode: bits 3 and 4 toggle on read/write data falls.
`timescale 1ns/1ns
`default_nettype none
`include "fdoc_map.svh"

module fdoc_top
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [`FDOC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [7:0] avs_readdata_tri,
  // configuration straps
  input wire fdoc_pkg::fdoc_mode_t cfg_mode,
  input wire logic cfg_ext_decode,
  input wire logic cfg_swap01,
  // drive interface
  input wire logic write_gate,
  input wire logic read_data_n,
  input wire logic write_data_n,
  input wire logic second_drive_present_n,
  output logic drive_sel_out_0_n,
  output logic drive_sel_out_1_n,
  output logic drive_sel_out_2_n,
  output logic drive_sel_out_3_n,
  output logic motor_out_0_n,
  output logic motor_out_1_n,
  output logic motor_out_2_n,
  output logic motor_out_3_n,
  // core control
  output logic ctl_reset,
  output logic dma_pin_enable,
  output logic dma_in_enable
);

  fdoc_pkg::fdoc_state_t s_reg;
  fdoc_pkg::fdoc_state_t s_next;
  logic [9:0] idx;
  logic hit_sb;
  logic hit_doc;
  logic hit_tss;
  logic hit_dir;
  logic dir_read;
  logic [1:0] code;
  logic [3:0] mtr;
  logic [3:0] sel_n;
  logic [3:0] int_sel_n;
  logic [7:0] sb_val;
  logic [7:0] rd_mux;
  logic [7:0] rd_float;
  // mode and bus phase helpers
  logic mode_basic;
  logic mode_alt;
  logic bus_first;
  logic bus_last;
  // one-cycle edge strobes from the synchronised drive lines
  logic wg_rise;
  logic rd_inact;
  logic wd_inact;
  // per-drive decode terms
  logic [3:0] drv_hit;
  logic [3:0] drv_on;
  logic [1:0] ext_code;
  logic ext_mtr_n;

  // word index from byte address
  assign idx = avs_address[`FDOC_ADDR_W-1:2];
  assign hit_sb = (idx == `FDOC_IDX_STATUS_B);
  assign hit_doc = (idx == `FDOC_IDX_DRV_CTRL);
  assign hit_tss = (idx == `FDOC_IDX_TAPE_SEL);
  assign hit_dir = (idx == `FDOC_IDX_DIG_IN);
  // answer taken in the ack cycle only, so side effects fire once
  assign dir_read = avs_read && hit_dir && bus_last;

  // mode decode, extended is everything that is neither of the others
  assign mode_basic = (cfg_mode == fdoc_pkg::fdoc_mode_basic);
  assign mode_alt = (cfg_mode == fdoc_pkg::fdoc_mode_alternate);

  // bus phases: first cycle takes the request, second answers it
  assign bus_first = (s_reg.bus == fdoc_pkg::fdoc_bus_idle);
  assign bus_last = (s_reg.bus == fdoc_pkg::fdoc_bus_ack);

  // edge strobes; the data lines are active low, so inactive means rising
  assign wg_rise = s_reg.wg_sync2 && !s_reg.wg_last;
  assign rd_inact = s_reg.rd_sync2 && !s_reg.rd_last;
  assign wd_inact = s_reg.wd_sync2 && !s_reg.wd_last;

  // motor bits and select code
  assign code = s_reg.doc[`FDOC_DOC_SEL_LO+1:`FDOC_DOC_SEL_LO];
  assign mtr = s_reg.doc[`FDOC_DOC_MTR_LO+3:`FDOC_DOC_MTR_LO];

  // internal decode: coded drive only when its motor bit is on
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sel
      // pins 0 and 1 answer each other's code when swapped, pins 2 and 3
      // never move; the motor bit follows the code, not the pin
      if (g < 2)
      begin : g_low
        assign drv_hit[g] = cfg_swap01 ? (code == 2'(g ^ 1)) :
          (code == 2'(g));
        assign drv_on[g] = cfg_swap01 ? mtr[g ^ 1] : mtr[g];
      end
      else
      begin : g_high
        assign drv_hit[g] = (code == 2'(g));
        assign drv_on[g] = mtr[g];
      end
      // a coded drive with its motor off stays deselected
      assign int_sel_n[g] = !(drv_hit[g] && drv_on[g]);
    end
  endgenerate

  // external decoder code: swap exchanges only codes 00 and 01
  always_comb
  begin
    ext_code = code;
    case (code)
      2'b00:
        if (cfg_swap01)
          ext_code = 2'b01;
      2'b01:
        if (cfg_swap01)
          ext_code = 2'b00;
      default:
        ext_code = code;
    endcase
  end

  // one shared motor line, low only while the coded drive runs; pins 2 and
  // 3 are not wired to the external decoder and stay inactive
  assign ext_mtr_n = !mtr[code];

  // pin decode per mode
  always_comb
  begin
    // internal decode: every motor pin follows its own bit, motor pins 0 and 1 exchange bits when swapped
    sel_n = int_sel_n;
    motor_out_2_n = !mtr[2];
    motor_out_3_n = !mtr[3];
    motor_out_0_n = !(cfg_swap01 ? mtr[1] : mtr[0]);
    motor_out_1_n = !(cfg_swap01 ? mtr[0] : mtr[1]);
    if (cfg_ext_decode)
    begin
      // external decode: two code lines feed a decoder outside
      sel_n = {2'b11, ext_code};
      motor_out_1_n = 1'b1;
      motor_out_0_n = ext_mtr_n;
      motor_out_2_n = 1'b1;
      motor_out_3_n = 1'b1;
    end
  end

  assign drive_sel_out_0_n = sel_n[0];
  assign drive_sel_out_1_n = sel_n[1];
  assign drive_sel_out_2_n = sel_n[2];
  assign drive_sel_out_3_n = sel_n[3];

  // status b contents per mode
  always_comb
  begin
    sb_val = 8'h00;
    if (mode_alt)
    begin
      // alternate layout: select pins, latches and the second drive pin
      sb_val[0] = sel_n[2];
      sb_val[1] = sel_n[3];
      sb_val[5] = sel_n[0];
      sb_val[6] = sel_n[1];
      sb_val[2] = s_reg.wg_latch;
      sb_val[3] = s_reg.rd_latch;
      sb_val[4] = s_reg.wd_latch;
      sb_val[7] = second_drive_present_n;
    end
    else
    begin
      // extended layout: mirrors of the register and toggles
      sb_val[7] = 1'b1;
      sb_val[6] = 1'b1;
      sb_val[5] = code[0];
      sb_val[4] = s_reg.wd_tog;
      sb_val[3] = s_reg.rd_tog;
      sb_val[2] = s_reg.wg_sync2;
      sb_val[1] = mtr[1];
      sb_val[0] = mtr[0];
    end
  end

  // read mux; unmapped reads return zero
  always_comb
  begin
    rd_mux = 8'h00;
    rd_float = 8'h00;
    if (hit_sb)
    begin
      rd_mux = sb_val;
      // basic mode keeps the whole byte off the bus
      if (mode_basic)
        rd_float = 8'hFF;
    end
    else if (hit_doc)
    begin
      rd_mux = s_reg.doc;
    end
    else if (hit_tss)
    begin
      // only the two select bits exist, the rest of the byte floats
      rd_mux = {6'h00, s_reg.tss};
      rd_float = 8'hFC;
    end
  end

  // one register update process for all state
  always_comb
  begin
    s_next = s_reg;
    // synchronisers, first stage read only by second
    s_next.wg_sync1 = write_gate;
    s_next.wg_sync2 = s_reg.wg_sync1;
    s_next.wg_last = s_reg.wg_sync2;
    s_next.rd_sync1 = read_data_n;
    s_next.rd_sync2 = s_reg.rd_sync1;
    s_next.rd_last = s_reg.rd_sync2;
    s_next.wd_sync1 = write_data_n;
    s_next.wd_sync2 = s_reg.wd_sync1;
    s_next.wd_last = s_reg.wd_sync2;
    // digital input read clears, a same-cycle edge wins
    if (dir_read)
    begin
      s_next.wg_latch = 1'b0;
      s_next.rd_latch = 1'b0;
      s_next.wd_latch = 1'b0;
    end
    // write gate latch, set on the line becoming active
    if (wg_rise)
    begin
      s_next.wg_latch = 1'b1;
    end
    // read data latch and toggle share one strobe
    if (rd_inact)
    begin
      s_next.rd_latch = 1'b1;
      s_next.rd_tog = !s_reg.rd_tog;
    end
    // write data counts whether or not the gate is open
    if (wd_inact)
    begin
      s_next.wd_latch = 1'b1;
      s_next.wd_tog = !s_reg.wd_tog;
    end
    // bus: one wait cycle, then answer
    s_next.bus = fdoc_pkg::fdoc_bus_idle;
    if ((avs_read || avs_write) && bus_first)
    begin
      s_next.bus = fdoc_pkg::fdoc_bus_ack;
    end
    // read data is captured in the wait cycle so it stands when answered
    if (avs_read && bus_first)
    begin
      s_next.rdata = rd_mux;
      s_next.rd_tri = rd_float;
    end
    // writes land in the answer cycle only, so each takes effect once
    if (avs_write && bus_last)
    begin
      if (hit_doc)
      begin
        s_next.doc = avs_writedata[7:0];
      end
      if (hit_tss)
      begin
        s_next.tss = avs_writedata[1:0];
      end
    end
    // controller reset stretched to the least pulse width; a bit written
    // low and high again in back-to-back writes still gives a full pulse
    if (!s_next.doc[`FDOC_DOC_RST_N])
    begin
      s_next.rst_cnt = 4'(`FDOC_SRST_CYC);
    end
    else if (s_reg.rst_cnt != 4'h0)
    begin
      s_next.rst_cnt = s_reg.rst_cnt - 4'h1;
    end
    s_next.ctl_rst = !s_next.doc[`FDOC_DOC_RST_N] || (s_next.rst_cnt != 4'h0);
  end

  // state register; soft reset never touches doc or tss
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
      s_reg.doc <= `FDOC_DOC_RESET;
      s_reg.tss <= `FDOC_TSS_RESET;
      s_reg.ctl_rst <= 1'b1;
      s_reg.rst_cnt <= 4'(`FDOC_SRST_CYC);
      // data lines idle high; starting their flops low would fake an edge
      s_reg.rd_sync1 <= 1'b1;
      s_reg.rd_sync2 <= 1'b1;
      s_reg.rd_last <= 1'b1;
      s_reg.wd_sync1 <= 1'b1;
      s_reg.wd_sync2 <= 1'b1;
      s_reg.wd_last <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // bus answer
  // waitrequest only in the first cycle, so every access costs two cycles
  assign avs_waitrequest = (avs_read || avs_write) && bus_first;
  // read data and float mask come from flops and stand until the next read
  assign avs_readdata = {24'h000000, s_reg.rdata};
  assign avs_readdata_tri = s_reg.rd_tri;

  // core reset and dma pin enables
  assign ctl_reset = s_reg.ctl_rst;
  // extended mode keeps the pins alive even while the enable bit is clear
  assign dma_pin_enable = (cfg_mode == fdoc_pkg::fdoc_mode_extended) ||
    s_reg.doc[`FDOC_DOC_DMA_EN];
  assign dma_in_enable = dma_pin_enable;

endmodule
`default_nettype wire

// File: sim/fdoc_top_props.sv
/* assertions on the ports of the drive output control block.
   assumes it is bound to fdoc_top and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
`include "fdoc_map.svh"
module fdoc_top_props
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bus
  input wire logic [`FDOC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] avs_readdata_tri,
  // straps and drive pins
  input wire fdoc_pkg::fdoc_mode_t cfg_mode,
  input wire logic cfg_ext_decode,
  input wire logic drive_sel_out_0_n,
  input wire logic drive_sel_out_1_n,
  input wire logic drive_sel_out_2_n,
  input wire logic drive_sel_out_3_n,
  input wire logic motor_out_0_n,
  input wire logic motor_out_1_n,
  input wire logic motor_out_2_n,
  input wire logic motor_out_3_n,
  // core control
  input wire logic ctl_reset,
  input wire logic dma_pin_enable,
  input wire logic dma_in_enable
);
  // pins as vectors, finished bus cycles by register
  wire logic [3:0] sel_n = {drive_sel_out_3_n, drive_sel_out_2_n,
    drive_sel_out_1_n, drive_sel_out_0_n};
  wire logic [3:0] mtr_n = {motor_out_3_n, motor_out_2_n, motor_out_1_n,
    motor_out_0_n};
  wire logic ext = cfg_mode == fdoc_pkg::fdoc_mode_extended;
  wire logic rd_b = avs_read && !avs_waitrequest
    && avs_address[11:2] == `FDOC_IDX_STATUS_B;
  wire logic wr_c = avs_write && !avs_waitrequest
    && avs_address[11:2] == `FDOC_IDX_DRV_CTRL;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_one_wait: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait");
  a_sel_single: assert property (!cfg_ext_decode |->
    $countones(sel_n) >= 3) else $error("two drives selected");
  a_sel_motor: assert property (!cfg_ext_decode |->
    (~sel_n & mtr_n) == 4'h0) else $error("select without motor");
  a_ext_motor: assert property (cfg_ext_decode |-> motor_out_1_n)
    else $error("motor 1 active");
  a_ext_dma: assert property (ext |-> dma_pin_enable && dma_in_enable)
    else $error("dma pins off");
  a_rst_hold: assert property (wr_c && !avs_writedata[2] |->
    ##2 ctl_reset [*2]) else $error("soft reset not held");
  a_tri_basic: assert property (rd_b |-> avs_readdata_tri ==
    {8{cfg_mode == fdoc_pkg::fdoc_mode_basic}}) else $error("bad float");
  a_ext_bit7: assert property (rd_b && ext |-> avs_readdata[7])
    else $error("status bit 7 low");
endmodule
bind fdoc_top fdoc_top_props fdoc_top_props_inst (.*);
`default_nettype wire

// File: sim/fdoc_drive_model.sv
/* drives on the far side: data and gate lines on bench request.
   assumes the bench holds kick for as long as a line stays active. */
`timescale 1ns/1ns
`default_nettype none
module fdoc_drive_model
(
  // requests: bit 0 write gate, bit 1 read data, bit 2 write data
  input wire logic [2:0] kick,
  input wire logic drv2_n,
  // drive lines
  output logic write_gate,
  output logic read_data_n,
  output logic write_data_n,
  output logic second_drive_present_n
);
  // data lines idle high, so release gives the inactive edge
  assign write_gate = kick[0];
  assign read_data_n = ~kick[1];
  assign write_data_n = ~kick[2];
  assign second_drive_present_n = drv2_n;
endmodule
`default_nettype wire

// File: sim/tb_top.sv
/* self-checking bench of the drive output control block.
   assumes the checker binds itself and the drive model stands beside. */
`timescale 1ns/1ns
`default_nettype none
`include "fdoc_map.svh"
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [`FDOC_ADDR_W-1:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  fdoc_pkg::fdoc_mode_t cfg_mode = fdoc_pkg::fdoc_mode_alternate;
  logic ext = 1'b0;
  logic swap = 1'b0;
  logic [2:0] kick = 3'h0;
  logic drv2_n = 1'b1;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, wg, rdn, wdn, d2n;
  wire logic ctl_reset, dma_pin_enable, dma_in_enable;
  wire logic [3:0] sel_n, mtr_n;
  wire logic [7:0] rd_tri;
  int fails = 0;
  int samples_checked = 0;
  integer seed = 78647;
  logic [7:0] rd, doc, p, r0;

  // bench clock
  always #4 clk = ~clk;

  fdoc_top fdoc_top_inst (.clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest,
    .avs_readdata_tri(rd_tri),
    .cfg_mode, .cfg_ext_decode(ext), .cfg_swap01(swap), .write_gate(wg),
    .read_data_n(rdn), .write_data_n(wdn), .second_drive_present_n(d2n),
    .drive_sel_out_0_n(sel_n[0]), .drive_sel_out_1_n(sel_n[1]),
    .drive_sel_out_2_n(sel_n[2]), .drive_sel_out_3_n(sel_n[3]),
    .motor_out_0_n(mtr_n[0]), .motor_out_1_n(mtr_n[1]),
    .motor_out_2_n(mtr_n[2]), .motor_out_3_n(mtr_n[3]), .ctl_reset,
    .dma_pin_enable, .dma_in_enable);

  fdoc_drive_model fdoc_drive_model_inst (.kick, .drv2_n, .write_gate(wg),
    .read_data_n(rdn), .write_data_n(wdn), .second_drive_present_n(d2n));

  // expected {selects, motors}, all active low
  function automatic logic [7:0] exp_pins(input logic [7:0] c,
    input logic x, input logic s);
    logic [1:0] d;
    logic [7:0] q;
    d = c[1:0] ^ {1'b0, s & ~c[1]};
    q = 8'hFF;
    if (x)
    begin
      q[5:4] = d;
      q[0] = ~c[4 + c[1:0]];
    end
    else
    begin
      q[3:0] = ~c[7:4];
      if (s)
        q[1:0] = ~{c[4], c[5]};
      q[4 + d] = ~c[4 + c[1:0]];
    end
    return q;
  endfunction

  // one avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] idx,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    @(posedge clk iff avs_waitrequest === 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t register %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t pins %h expected %h", $time, got, exp);
    end
  endtask

  // lines stay active five cycles, then time for the sync flops
  task automatic pulse(input logic [2:0] k);
    kick <= k;
    repeat (5) @(posedge clk);
    kick <= 3'h0;
    repeat (8) @(posedge clk);
  endtask

  // activity, status read, then the clearing read
  task automatic sb_step(input logic [2:0] k);
    p = exp_pins(doc, 1'b0, 1'b0);
    pulse(k);
    bus(1'b0, `FDOC_IDX_STATUS_B, 8'h00, rd);
    chk_reg(rd, {drv2_n, p[5], p[4], k, p[7], p[6]});
    bus(1'b0, `FDOC_IDX_DIG_IN, 8'h00, rd);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, `FDOC_IDX_DRV_CTRL, 8'h00, rd);
    chk_reg(rd, 8'h00);
    chk_pin({sel_n, mtr_n}, 8'hFF);
    $display("reset test done");
    for (int v = 0; v < 4; v++)
      for (int n = 0; n < 12; n++)
      begin
        ext <= v[1];
        swap <= v[0];
        doc = 8'($random(seed));
        if (n < 4)
          doc = {4'h1 << n, 4'hC + n[3:0]};
        bus(1'b1, `FDOC_IDX_DRV_CTRL, doc, rd);
        bus(1'b0, `FDOC_IDX_DRV_CTRL, 8'h00, rd);
        chk_reg(rd, doc);
        chk_pin({sel_n, mtr_n}, exp_pins(doc, v[1], v[0]));
      end
    $display("decode test done");
    doc = 8'h2D;
    bus(1'b1, `FDOC_IDX_DRV_CTRL, doc, rd);
    for (int t = 0; t < 4; t++)
    begin
      bus(1'b1, `FDOC_IDX_TAPE_SEL, {6'($random(seed)), t[1:0]}, rd);
      bus(1'b1, `FDOC_IDX_DRV_CTRL, doc & 8'hFB, rd);
      bus(1'b1, `FDOC_IDX_DRV_CTRL, doc, rd);
      // reset bit is high again, the stretched pulse must still stand
      repeat (4) @(posedge clk);
      chk_pin({7'h00, ctl_reset}, 8'h01);
      bus(1'b0, `FDOC_IDX_TAPE_SEL, 8'h00, rd);
      chk_reg(rd, {6'h00, t[1:0]});
      chk_reg(rd_tri, 8'hFC);
      bus(1'b0, `FDOC_IDX_DRV_CTRL, 8'h00, rd);
      chk_reg(rd, doc);
    end
    repeat (16) @(posedge clk);
    chk_pin({7'h00, ctl_reset}, 8'h00);
    $display("soft reset test done");
    ext <= 1'b0;
    swap <= 1'b0;
    drv2_n <= 1'b0;
    bus(1'b0, `FDOC_IDX_DIG_IN, 8'h00, rd);
    chk_pin({6'h00, dma_pin_enable, dma_in_enable}, 8'h03);
    sb_step(3'h0);
    sb_step(3'h4);
    sb_step(3'h3);
    $display("status test done");
    cfg_mode <= fdoc_pkg::fdoc_mode_extended;
    bus(1'b0, `FDOC_IDX_STATUS_B, 8'h00, r0);
    pulse(3'h6);
    bus(1'b0, `FDOC_IDX_STATUS_B, 8'h00, rd);
    chk_reg(rd & 8'hF8, {2'b11, doc[0], ~r0[4:3], 3'b000});
    // enable bit cleared while extended: the pins must stay on
    bus(1'b1, `FDOC_IDX_DRV_CTRL, doc & 8'hF7, rd);
    @(posedge clk);
    chk_pin({6'h00, dma_pin_enable, dma_in_enable}, 8'h03);
    cfg_mode <= fdoc_pkg::fdoc_mode_basic;
    @(posedge clk);
    chk_pin({6'h00, dma_pin_enable, dma_in_enable}, 8'h00);
    bus(1'b0, `FDOC_IDX_STATUS_B, 8'h00, rd);
    chk_reg(rd_tri, 8'hFF);
    bus(1'b0, 10'h3F6, 8'h00, rd);
    chk_reg(rd, 8'h00);
    $display("mode test done");
    end_sim();
  end

  // watchdog against a hung handshake
  initial
  begin
    #100000;
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
